// file: common/ubd_regs.svh
// register map, field positions and reset values of the descriptor block
// assumes inclusion by the top module and the testbench only
`ifndef UBD_REGS_SVH
`define UBD_REGS_SVH

// word offsets inside the block window (byte addresses)
`define UBD_OFS_OTG_IE 10'h000
`define UBD_OFS_OTG_IF 10'h004
`define UBD_OFS_CTRL 10'h008
`define UBD_OFS_STATE 10'h00C
// descriptor table occupies 10'h100 .. 10'h1FC, selected by address bits 9:8
`define UBD_TABLE_SEL 2'h1

// otg interrupt enable: implemented bits and reset value
`define UBD_IE_MASK 8'hFD
`define UBD_IE_RESET 8'h00

// descriptor status word fields
`define UBD_OWN_BIT 7
`define UBD_PID_LSB 2
`define UBD_PID_MSB 5
`define UBD_CNT_LSB 16
`define UBD_CNT_MSB 25
// status word bits the engine rewrites: count, owner and pid
`define UBD_ENG_FIELDS 32'h03FF_00BC

// control register fields
`define UBD_CTRL_MODE_LSB 0
`define UBD_CTRL_MODE_MSB 1
`define UBD_CTRL_EP_LSB 16
`define UBD_CTRL_EP_MSB 31

// common reset values
`define UBD_WORD_ZERO 32'h0000_0000
`define UBD_EP_EN_RESET 16'h0000
`define UBD_BYTE_ZERO 8'h00

`endif

// file: common/ubd_pkg.sv
// types shared by the descriptor block modules
// assumes ubd_regs.svh is on the include path
package ubd_pkg;
  // buffering modes fix the descriptor to endpoint mapping
  typedef enum logic [1:0] {
    UBD_MODE_NONE = 2'h0,
    UBD_MODE_EP0_OUT = 2'h1,
    UBD_MODE_ALL = 2'h2,
    UBD_MODE_NOT_EP0 = 2'h3
  } ubd_mode_t;

  // engine side descriptor access sequencer, one-hot
  typedef enum logic [2:0] {
    UBD_ST_IDLE = 3'h1,
    UBD_ST_FETCH = 3'h2,
    UBD_ST_UPDATE = 3'h4
  } ubd_state_t;

  // request from the serial engine at the end of a transaction
  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    logic dir_in;
    logic odd;
    logic [3:0] pid;
    logic [9:0] count;
  } ubd_eng_req_t;

  // answer to the serial engine
  typedef struct packed {
    logic done;
    logic ok;
    logic [5:0] index;
    logic [31:0] word;
  } ubd_eng_rsp_t;

  // state of the top module apart from the event flags
  typedef struct packed {
    ubd_state_t fsm;
    ubd_mode_t mode;
    logic [15:0] ep_en;
    logic [7:0] ie;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic rd_pend;
    logic [7:0] rd_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic eng_ready;
    ubd_eng_req_t req;
    logic ep_ok;
    logic [5:0] idx;
    logic [31:0] cur_word;
    ubd_eng_rsp_t rsp;
    logic [7:0] refused;
    logic [63:0][31:0] table_w;
  } ubd_top_state_t;
endpackage : ubd_pkg

// file: core/ubd_flag_bank.sv
// sticky event flags, set by hardware, cleared by writing ones
// assumes set and clear are one-cycle strobes on the same clock
`timescale 1ns/1ps
module ubd_flag_bank #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // events and software clear
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // held flags
  output logic [W-1:0] flags
);
  logic [W-1:0] next_flags; // next flag value

  // a set in the clearing cycle survives so no event is lost
  always_comb begin
    next_flags = (flags & ~clr) | set;
  end

  // flag register
  always_ff @(posedge clock) begin
    if (rst) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end
endmodule : ubd_flag_bank

// file: core/ubd_bd_map.sv
// fixed endpoint to descriptor index mapping for the four buffering modes
// assumes purely combinational use by the engine sequencer
`timescale 1ns/1ps
module ubd_bd_map import ubd_pkg::*; (
  // selection
  input ubd_mode_t mode,
  input wire logic [3:0] ep,
  input wire logic dir_in,
  input wire logic odd,
  // result
  output logic [5:0] index
);
  logic [6:0] n; // endpoint number widened for arithmetic
  logic [6:0] d; // direction as a number
  logic [6:0] o; // parity as a number
  logic [6:0] sum; // raw index before narrowing

  // the table never moves: disabled endpoints leave holes
  always_comb begin
    n = {3'h0, ep};
    d = {6'h00, dir_in};
    o = {6'h00, odd};
    sum = 7'h00;
    case (mode)
      UBD_MODE_NONE: begin
        sum = (n << 1) + d;
      end
      UBD_MODE_EP0_OUT: begin
        if (ep == 4'h0) begin
          sum = dir_in ? 7'h02 : o;
        end else begin
          sum = (n << 1) + 7'h01 + d;
        end
      end
      UBD_MODE_ALL: begin
        sum = (n << 2) + (d << 1) + o;
      end
      UBD_MODE_NOT_EP0: begin
        if (ep == 4'h0) begin
          sum = d;
        end else begin
          sum = (n << 2) - 7'h02 + (d << 1) + o;
        end
      end
      default: begin
        sum = 7'h00;
      end
    endcase
    index = sum[5:0];
  end
endmodule : ubd_bd_map

// file: core/ubd_top.sv
// descriptor ownership, engine descriptor access and otg interrupt enable
// assumes a single ahb-lite master and a serial engine on the same clock
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ubd_regs.svh"
module ubd_top import ubd_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // ahb-lite register slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial engine descriptor port
  input ubd_eng_req_t eng_req,
  output logic eng_ready,
  output ubd_eng_rsp_t eng_rsp,
  // otg status and interrupt
  input wire logic host_mode,
  input wire logic [7:0] otg_event,
  output logic irq
);
  ubd_top_state_t st; // registered state
  ubd_top_state_t next_st; // next state
  logic take; // address phase accepted this cycle
  logic [7:0] flag_clr; // software clear strobes
  logic [7:0] flags; // sticky otg event flags
  logic [5:0] map_idx; // descriptor index for the incoming request
  logic [31:0] upd_word; // status word rewritten by the engine

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // descriptor index lookup for the pending engine request
  ubd_bd_map ubd_bd_map_i (
    .mode(st.mode),
    .ep(eng_req.ep),
    .dir_in(eng_req.dir_in),
    .odd(eng_req.odd),
    .index(map_idx)
  );

  // otg event flags; bit 1 has no enable and never raises the line
  ubd_flag_bank #(.W(8)) ubd_flag_bank_i (
    .clock(clock),
    .rst(rst),
    .set(otg_event),
    .clr(flag_clr),
    .flags(flags)
  );

  // register read mux; unmapped words read as zero
  function automatic logic [31:0] read_word(input ubd_top_state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = `UBD_WORD_ZERO;
    if (a[7:6] == `UBD_TABLE_SEL) begin
      r = s.table_w[a[5:0]];
    end else if ({a, 2'b00} == `UBD_OFS_OTG_IE) begin
      r = host_mode ? {24'h00_0000, s.ie} : `UBD_WORD_ZERO;
    end else if ({a, 2'b00} == `UBD_OFS_OTG_IF) begin
      r = {24'h00_0000, flags};
    end else if ({a, 2'b00} == `UBD_OFS_CTRL) begin
      r = {s.ep_en, 14'h0000, s.mode};
    end else if ({a, 2'b00} == `UBD_OFS_STATE) begin
      r = {8'h00, s.refused, 2'b00, s.idx, 5'h00, s.fsm};
    end
    return r;
  endfunction : read_word

  ////////////////////////////////////////////////////////////////////////////
  // next state

  // bus slave, register writes and the engine sequencer in one process
  always_comb begin
    next_st = st;
    next_st.rsp.done = 1'b0;
    next_st.wr_pend = 1'b0;
    flag_clr = `UBD_BYTE_ZERO;
    upd_word = st.cur_word;
    take = hsel & htrans[1] & hready;
    // address phase: writes take no wait, reads one wait state
    if (take) begin
      next_st.wr_pend = hwrite;
      next_st.wr_addr = haddr[9:2];
      next_st.rd_addr = haddr[9:2];
      if (!hwrite) begin
        next_st.rd_pend = 1'b1;
        next_st.hreadyout = 1'b0;
      end
    end
    // read data phase: data taken after any earlier write has landed
    if (st.rd_pend) begin
      next_st.hrdata = read_word(st, st.rd_addr);
      next_st.hreadyout = 1'b1;
      next_st.rd_pend = 1'b0;
    end
    // write data phase
    if (st.wr_pend) begin
      if (st.wr_addr[7:6] == `UBD_TABLE_SEL) begin
        // core may only touch descriptors it owns
        if (!st.table_w[st.wr_addr[5:0]][`UBD_OWN_BIT]) begin
          next_st.table_w[st.wr_addr[5:0]] = hwdata;
        end
      end else if ({st.wr_addr, 2'b00} == `UBD_OFS_OTG_IE) begin
        if (host_mode) begin
          next_st.ie = hwdata[7:0] & `UBD_IE_MASK;
        end
      end else if ({st.wr_addr, 2'b00} == `UBD_OFS_OTG_IF) begin
        flag_clr = hwdata[7:0];
      end else if ({st.wr_addr, 2'b00} == `UBD_OFS_CTRL) begin
        next_st.mode = ubd_mode_t'(hwdata[`UBD_CTRL_MODE_MSB:`UBD_CTRL_MODE_LSB]);
        next_st.ep_en = hwdata[`UBD_CTRL_EP_MSB:`UBD_CTRL_EP_LSB];
      end
    end
    // engine side: fetch the descriptor, then hand it back
    case (st.fsm)
      UBD_ST_IDLE: begin
        if (eng_req.valid && st.eng_ready) begin
          next_st.req = eng_req;
          next_st.idx = map_idx;
          next_st.ep_ok = st.ep_en[eng_req.ep];
          next_st.eng_ready = 1'b0;
          next_st.fsm = UBD_ST_FETCH;
        end
      end
      UBD_ST_FETCH: begin
        next_st.cur_word = st.table_w[st.idx];
        if (st.ep_ok && st.table_w[st.idx][`UBD_OWN_BIT]) begin
          next_st.fsm = UBD_ST_UPDATE;
        end else begin
          // core owns it or the endpoint is off: leave it untouched
          next_st.rsp.done = 1'b1;
          next_st.rsp.ok = 1'b0;
          next_st.rsp.index = st.idx;
          next_st.rsp.word = st.table_w[st.idx];
          next_st.refused = st.refused + 8'h01;
          next_st.eng_ready = 1'b1;
          next_st.fsm = UBD_ST_IDLE;
        end
      end
      UBD_ST_UPDATE: begin
        // engine view of the word: only the owner bit keeps its meaning
        upd_word[`UBD_PID_MSB:`UBD_PID_LSB] = st.req.pid;
        upd_word[`UBD_CNT_MSB:`UBD_CNT_LSB] = st.req.count;
        upd_word[`UBD_OWN_BIT] = 1'b0;
        next_st.table_w[st.idx] = upd_word;
        next_st.rsp.done = 1'b1;
        next_st.rsp.ok = 1'b1;
        next_st.rsp.index = st.idx;
        next_st.rsp.word = st.cur_word;
        next_st.eng_ready = 1'b1;
        next_st.fsm = UBD_ST_IDLE;
      end
      default: begin
        next_st.eng_ready = 1'b1;
        next_st.fsm = UBD_ST_IDLE;
      end
    endcase
    // masking hides the request but keeps the flag
    next_st.irq = |(flags & st.ie);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // the state register resets in one place, table included; the event flags reset in the flag bank
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '0;
      st.fsm <= UBD_ST_IDLE;
      st.mode <= UBD_MODE_NONE;
      st.ep_en <= `UBD_EP_EN_RESET;
      st.ie <= `UBD_IE_RESET;
      st.hreadyout <= 1'b1;
      st.eng_ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign hrdata = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp = st.hresp;
  assign eng_ready = st.eng_ready;
  assign eng_rsp = st.rsp;
  assign irq = st.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // engine request accepted, then fetch
  sequence eng_take_s;
    eng_req.valid && eng_ready;
  endsequence
  // fetch followed by the answer within two edges
  sequence fetch_answer_s;
    (st.fsm == UBD_ST_FETCH) ##[1:2] eng_rsp.done;
  endsequence

  dma_fetch_path_a: assert property (eng_take_s |=> fetch_answer_s)
    else $error("engine request not answered after fetch");

  owner_guard_a: assert property (
    (st.fsm == UBD_ST_FETCH && !st.table_w[st.idx][`UBD_OWN_BIT] && !st.wr_pend)
    |=> eng_rsp.done && !eng_rsp.ok && st.table_w[eng_rsp.index] == eng_rsp.word)
    else $error("engine altered a core owned descriptor");

  update_write_a: assert property (
    (st.fsm == UBD_ST_UPDATE) |=> eng_rsp.ok
    && st.table_w[eng_rsp.index][`UBD_PID_MSB:`UBD_PID_LSB] == $past(st.req.pid)
    && st.table_w[eng_rsp.index][`UBD_CNT_MSB:`UBD_CNT_LSB] == $past(st.req.count)
    && !st.table_w[eng_rsp.index][`UBD_OWN_BIT])
    else $error("engine write back wrong");

  read_wait_a: assert property (
    (hsel && htrans[1] && hready && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read data phase timing wrong");

  ie_reserved_a: assert property ((st.ie & ~`UBD_IE_MASK) == 8'h00)
    else $error("unimplemented enable bit set");

  ie_host_only_a: assert property (
    (st.wr_pend && !host_mode && {st.wr_addr, 2'b00} == `UBD_OFS_OTG_IE)
    |=> $stable(st.ie))
    else $error("enable register written outside host mode");

  // a masked flag keeps the line low, an unmasked one raises it next cycle
  irq_cause_a: assert property (((flags & st.ie) == `UBD_BYTE_ZERO) |=> !irq)
    else $error("interrupt does not follow flags and enables");

  irq_raise_a: assert property (((flags & st.ie) != `UBD_BYTE_ZERO) |=> irq)
    else $error("unmasked flag did not raise the interrupt");

  map_none_a: assert property (
    (st.mode == UBD_MODE_NONE) |-> map_idx == {eng_req.ep, eng_req.dir_in})
    else $error("plain mapping wrong");

  map_all_a: assert property (
    (st.mode == UBD_MODE_ALL) |-> map_idx == {eng_req.ep, eng_req.dir_in, eng_req.odd})
    else $error("full ping-pong mapping wrong");

  map_ep0_pp_a: assert property (
    (st.mode == UBD_MODE_EP0_OUT && eng_req.ep == 4'h0 && eng_req.dir_in)
    |-> map_idx == 6'h02)
    else $error("ep0 in index wrong in ep0 ping-pong mode");

  map_not_ep0_a: assert property (
    (st.mode == UBD_MODE_NOT_EP0 && eng_req.ep == 4'h0) |-> map_idx == {5'h00, eng_req.dir_in})
    else $error("ep0 index wrong in partial ping-pong mode");

  ep_off_a: assert property (
    (eng_take_s ##0 !st.ep_en[eng_req.ep]) |=> ##1 eng_rsp.done && !eng_rsp.ok)
    else $error("disabled endpoint served");

  // core side writes: land while the core owns the word, dropped otherwise
  sequence core_table_wr_s;
    st.wr_pend && !take && st.wr_addr[7:6] == `UBD_TABLE_SEL;
  endsequence

  core_write_a: assert property (
    (core_table_wr_s ##0 !st.table_w[st.wr_addr[5:0]][`UBD_OWN_BIT])
    |=> st.table_w[st.wr_addr[5:0]] == $past(hwdata))
    else $error("core write to a core owned descriptor lost");

  core_hands_off_a: assert property (
    (core_table_wr_s ##0
      (st.table_w[st.wr_addr[5:0]][`UBD_OWN_BIT] && st.fsm != UBD_ST_UPDATE))
    |=> $stable(st.table_w[st.wr_addr[5:0]]))
    else $error("core write reached an engine owned descriptor");

  // engine write back leaves every other bit of the word alone
  engine_keeps_rest_a: assert property (
    (st.fsm == UBD_ST_UPDATE) |=> (st.table_w[eng_rsp.index] & ~`UBD_ENG_FIELDS)
    == ($past(st.cur_word) & ~`UBD_ENG_FIELDS))
    else $error("engine write back touched unrelated bits");

  // engine handshake: busy while a descriptor is in flight, one-cycle answer
  busy_not_ready_a: assert property ((st.fsm != UBD_ST_IDLE) |-> !eng_ready)
    else $error("engine port ready while a descriptor is in flight");

  done_pulse_a: assert property (eng_rsp.done |=> !eng_rsp.done)
    else $error("engine answer held longer than one cycle");

  // enable register: reset clears it, host writes keep implemented bits only
  ie_reset_a: assert property (
    $fell(rst) |-> st.ie == `UBD_IE_RESET && flags == `UBD_BYTE_ZERO)
    else $error("enable or flags not cleared by reset");

  ie_write_a: assert property (
    (st.wr_pend && host_mode && {st.wr_addr, 2'b00} == `UBD_OFS_OTG_IE)
    |=> {24'h00_0000, st.ie} == ($past(hwdata) & {24'h00_0000, `UBD_IE_MASK}))
    else $error("enable write did not keep the implemented bits");

  ie_device_read_a: assert property (
    (st.rd_pend && !host_mode && {st.rd_addr, 2'b00} == `UBD_OFS_OTG_IE)
    |=> hrdata == `UBD_WORD_ZERO)
    else $error("enable register visible outside host mode");

  // flags drop only through a software clear, never through masking
  flags_keep_a: assert property (
    (flag_clr == `UBD_BYTE_ZERO) |=> (flags & $past(flags)) == $past(flags))
    else $error("event flag lost without a clear");

  // ep0 out takes both even and odd slots when only it ping-pongs
  map_ep0_out_a: assert property (
    (st.mode == UBD_MODE_EP0_OUT && eng_req.ep == 4'h0 && !eng_req.dir_in)
    |-> map_idx == {5'h00, eng_req.odd})
    else $error("ep0 out index wrong in ep0 ping-pong mode");

  // shifted layouts: endpoints past zero move up one slot for the ep0 out extra, or down two where ep0 does not ping-pong
  map_ep_shift_a: assert property (
    (st.mode == UBD_MODE_EP0_OUT && eng_req.ep != 4'h0)
    |-> map_idx == {1'b0, eng_req.ep, 1'b1} + {5'h00, eng_req.dir_in})
    else $error("shifted mapping wrong in ep0 ping-pong mode");

  map_pp_shift_a: assert property (
    (st.mode == UBD_MODE_NOT_EP0 && eng_req.ep != 4'h0)
    |-> map_idx == {eng_req.ep, eng_req.dir_in, eng_req.odd} - 6'h02)
    else $error("endpoint mapping wrong in partial ping-pong mode");
endmodule : ubd_top

// file: testbench/ubd_eng_model.sv
// serial engine stand-in: raises descriptor requests and collects the answers
// assumes the descriptor port of ubd_top on the same rising clock
`timescale 1ns/1ps
module ubd_eng_model import ubd_pkg::*; (
  // clock
  input wire logic clock,
  // descriptor port
  input wire logic eng_ready,
  input ubd_eng_rsp_t eng_rsp,
  output ubd_eng_req_t eng_req
);
  ////////////////////////////////////////////////////////////////////////////////
  // idle until the first request
  initial eng_req = '0;

  // one transaction end; gap idles first so a slow engine is exercised too
  task automatic xfer(input logic [3:0] ep, input logic dir_in, input logic odd,
    input logic [3:0] pid, input logic [9:0] count, input int gap,
    output ubd_eng_rsp_t rsp);
    repeat (gap) @(posedge clock);
    // request held until taken; pid and count go back into the status word
    eng_req <= ubd_eng_req_t'({1'b1, ep, dir_in, odd, pid, count});
    do @(negedge clock); while (eng_ready !== 1'b1);
    @(posedge clock);
    // released fields flip so a stale request never looks current
    eng_req <= ubd_eng_req_t'(~{1'b1, ep, dir_in, odd, pid, count});
    do @(negedge clock); while (eng_rsp.done !== 1'b1);
    rsp = eng_rsp;
    @(posedge clock);
  endtask : xfer
endmodule : ubd_eng_model

// file: testbench/usb_buffer_descriptor_ownership_test.sv
// self-checking bench: register bus, otg interrupt and descriptor engine port
// assumes ubd_pkg, ubd_top and ubd_eng_model are compiled before it
`timescale 1ns/1ps
`include "ubd_regs.svh"
module usb_buffer_descriptor_ownership_test import ubd_pkg::*;;
  ////////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010; // whole words only
  logic [31:0] hwdata = '0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  ubd_eng_req_t eng_req;
  logic eng_ready;
  ubd_eng_rsp_t eng_rsp;
  logic host_mode = 1'b1;
  logic [7:0] otg_event = 8'h00;
  logic irq;
  int errors = 0;
  int check_count = 0;
  ubd_eng_rsp_t rsp;
  logic [31:0] w;
  logic [5:0] ix;
  localparam logic [31:0] A_IE = {22'h0, `UBD_OFS_OTG_IE};
  localparam logic [31:0] A_IF = {22'h0, `UBD_OFS_OTG_IF};
  localparam logic [31:0] A_CTRL = {22'h0, `UBD_OFS_CTRL};

  // the single slave drives the bus ready
  assign hready = hreadyout;
  always #12.5 clock = ~clock;

  ubd_top ubd_top_i (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .eng_req(eng_req), .eng_ready(eng_ready),
    .eng_rsp(eng_rsp), .host_mode(host_mode), .otg_event(otg_event), .irq(irq));
  ubd_eng_model ubd_eng_model_i (.clock(clock), .eng_ready(eng_ready), .eng_rsp(eng_rsp),
    .eng_req(eng_req));

  ////////////////////////////////////////////////////////////////////////////////
  // compare and report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // single transfer; ready is looked at on the falling edge before each sampling edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    do @(negedge clock); while (hreadyout !== 1'b1);
    @(posedge clock);
    htrans <= 2'b00;
    hwdata <= d;
    do @(negedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
    @(posedge clock);
  endtask : ahb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0000_0000, q);
    chk(what, exp, q);
  endtask : rdc

  // one-cycle event strobe
  task automatic pulse(input logic [7:0] ev);
    otg_event <= ev;
    @(posedge clock);
    otg_event <= 8'h00;
    @(posedge clock);
  endtask : pulse

  // irq is sampled mid-cycle, away from the edge that updates it
  task automatic irq_is(input logic exp);
    @(negedge clock);
    chk("irq", 32'(exp), 32'(irq));
    @(posedge clock);
  endtask : irq_is

  // descriptor index the buffering mode fixes for an endpoint
  function automatic logic [5:0] exp_idx(input int m, input int e, input int di, input int od);
    case (m)
      0: return 6'(2 * e + di);
      1: return (e == 0) ? 6'(di ? 2 : od) : 6'(2 * e + 1 + di);
      2: return 6'(4 * e + 2 * di + od);
      default: return (e == 0) ? 6'(di) : 6'(4 * e - 2 + 2 * di + od);
    endcase
  endfunction : exp_idx

  function automatic logic [31:0] tbl(input logic [5:0] i);
    return 32'h0000_0100 + {24'h0, i, 2'b00};
  endfunction : tbl

  task automatic complete_run();
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin : main
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdc("enable reset", A_IE, 32'h0000_0000);
    rdc("flags reset", A_IF, 32'h0000_0000);
    rdc("unmapped", 32'h0000_0040, 32'h0000_0000);
    // each enable bit alone: raise, mask, clear
    for (int i = 0; i < 8; i++) begin
      wr(A_IE, 32'h0000_0001 << i);
      rdc("enable bit", A_IE, (32'h0000_0001 << i) & 32'h0000_00FD);
      pulse(8'(8'h01 << i));
      irq_is(i != 1);
      wr(A_IE, 32'h0000_0000);
      @(posedge clock);
      irq_is(1'b0);
      rdc("flag kept", A_IF, 32'h0000_0001 << i);
      wr(A_IF, 32'h0000_0001 << i);
      rdc("flag cleared", A_IF, 32'h0000_0000);
    end
    // enable register exists in host mode only
    wr(A_IE, 32'hFFFF_FFFF);
    rdc("enable all", A_IE, 32'h0000_00FD);
    host_mode <= 1'b0;
    @(posedge clock);
    rdc("enable device", A_IE, 32'h0000_0000);
    wr(A_IE, 32'h0000_0000);
    host_mode <= 1'b1;
    @(posedge clock);
    rdc("enable kept", A_IE, 32'h0000_00FD);
    // every mode, endpoint, direction and parity; slower engine in later modes
    for (int m = 0; m < 4; m++) begin
      wr(A_CTRL, {16'hFFFF, 14'h0000, 2'(m)});
      for (int e = 0; e < 16; e++) begin
        for (int k = 0; k < 4; k++) begin
          ix = exp_idx(m, e, k / 2, k % 2);
          w = 32'hC000_4080 | {18'h0, ix, 8'h00};
          wr(tbl(ix), w);
          rdc("owned word", tbl(ix), w);
          ubd_eng_model_i.xfer(4'(e), k >= 2, k[0], 4'(e + m), {ix, 4'h9}, m, rsp);
          chk("index", {26'h0, ix}, {26'h0, rsp.index});
          chk("served", 32'h0000_0001, 32'(rsp.ok));
          chk("old word", w, rsp.word);
          rdc("new word", tbl(ix),
            (w & ~32'h03FF_00BC) | {6'h0, ix, 4'h9, 10'h0, 4'(e + m), 2'h0});
        end
      end
    end
    // owner clear: the engine is refused and leaves the word alone
    wr(tbl(6'd2), 32'h0000_1234);
    ubd_eng_model_i.xfer(4'h1, 1'b0, 1'b0, 4'h3, 10'h3FF, 0, rsp);
    chk("refused", 32'h0000_0000, 32'(rsp.ok));
    rdc("untouched", tbl(6'd2), 32'h0000_1234);
    // core write while the engine owns the descriptor is dropped
    wr(tbl(6'd2), 32'h0000_0080);
    wr(tbl(6'd2), 32'h0000_5555);
    rdc("owned kept", tbl(6'd2), 32'h0000_0080);
    // disabled endpoint: its descriptor is a gap, not served
    wr(A_CTRL, 32'hFFFD_0003);
    ubd_eng_model_i.xfer(4'h1, 1'b0, 1'b0, 4'h3, 10'h001, 0, rsp);
    chk("disabled ep", 32'h0000_0000, 32'(rsp.ok));
    rdc("gap kept", tbl(6'd2), 32'h0000_0080);
    rdc("control", A_CTRL, 32'hFFFD_0003);
    // two refusals so far, last index 2, sequencer back to idle
    rdc("refusals", {22'h0, `UBD_OFS_STATE}, 32'h0002_0201);
    @(negedge clock);
    chk("engine ready", 32'h0000_0001, 32'(eng_ready));
    chk("response", 32'h0000_0000, 32'(hresp));
    complete_run();
  end

  // cuts a hang short, well beyond the few thousand cycles the tests need
  initial begin : watchdog
    repeat (20000) @(posedge clock);
    errors++;
    complete_run();
  end
endmodule : usb_buffer_descriptor_ownership_test
